// file: include/fcs_pkg.sv
/*
 * Shared types and constants of the flash command sequencer host.
 * Assumes a 10 MHz clock and a byte-wide flash with 17 address bits.
 */
package fcs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int T_ACC_NS = 150;
    localparam int T_WE_NS = 100;
    localparam int T_WIN_US = 50;
    localparam logic [3:0] RD_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 3);
    localparam logic [3:0] WE_CYC = 4'((T_WE_NS + CLK_NS - 1) / CLK_NS + 1);
    localparam logic [9:0] WIN_CYC = 10'(T_WIN_US * 1000 / CLK_NS);

    // ------------------------------------------------------------
    // Command coding
    // ------------------------------------------------------------
    localparam logic [16:0] ADDR_U1 = 17'h00555;
    localparam logic [16:0] ADDR_U2 = 17'h002aa;
    localparam logic [7:0] DATA_U1 = 8'haa;
    localparam logic [7:0] DATA_U2 = 8'h55;
    localparam logic [7:0] DATA_RESET = 8'hf0;
    localparam logic [7:0] DATA_IDENT = 8'h90;
    localparam logic [7:0] DATA_PROG = 8'ha0;
    localparam logic [7:0] DATA_ERASE = 8'h80;
    localparam logic [7:0] DATA_CHIP = 8'h10;
    localparam logic [7:0] DATA_SECT = 8'h30;
    localparam int SECT_LSB = 14;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_LIMIT = 5;
    localparam int BIT_WINDOW = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_RESET,
        CMD_IDENT,
        CMD_PROG,
        CMD_CHIP_ERASE,
        CMD_SECT_ERASE
    } fcs_cmd_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] data;
    } fcs_bus_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] dq_out;
        logic [7:0] dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fcs_pins_t;

endpackage

// file: src/fcs_cycle.sv
/*
 * One flash bus cycle, read or write; write strobe timing is fixed, reads end once two samples agree.
 * Assumes go_in is a one-cycle pulse given only while the engine is idle.
 */
module fcs_cycle (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Request
    input wire logic go_in,
    input wire logic wr_in,
    input wire fcs_pkg::fcs_bus_t bus_in,
    // Flash data pins
    input wire logic [7:0] dq_in,
    // Results
    output fcs_pkg::fcs_pins_t pins_out,
    output logic [7:0] rdata_out,
    output logic done_out
);

    typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ} fcs_cst_t;

    typedef struct packed {
        fcs_cst_t st;
        logic [3:0] cnt;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] rdata;
        logic done;
        fcs_pkg::fcs_pins_t pins;
    } fcs_cyc_state_t;

    fcs_cyc_state_t s_r;
    fcs_cyc_state_t s_nxt;

    // ------------------------------------------------------------
    // Cycle sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.s1 = dq_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        case (s_r.st)
            C_IDLE:
            begin
                if (go_in)
                begin
                    // Address is held from chip select falling to the cycle end.
                    s_nxt.pins.addr = bus_in.addr;
                    s_nxt.pins.ce_n = 1'b0;
                    if (wr_in)
                    begin
                        s_nxt.pins.dq_out = bus_in.data;
                        s_nxt.pins.dq_oe = 8'hff;
                        s_nxt.st = C_SETUP;
                    end
                    else
                    begin
                        s_nxt.pins.oe_n = 1'b0;
                        s_nxt.cnt = fcs_pkg::RD_CYC;
                        s_nxt.st = C_READ;
                    end
                end
            end
            C_SETUP:
            begin
                s_nxt.pins.we_n = 1'b0;
                s_nxt.cnt = fcs_pkg::WE_CYC;
                s_nxt.st = C_STROBE;
            end
            C_STROBE:
            begin
                if (s_r.cnt == 4'h1)
                begin
                    // Data stays driven past the write strobe rising edge.
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.st = C_HOLD;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            C_HOLD:
            begin
                s_nxt.pins.ce_n = 1'b1;
                s_nxt.pins.dq_oe = 8'h00;
                s_nxt.done = 1'b1;
                s_nxt.st = C_IDLE;
            end
            C_READ:
            begin
                if (s_r.cnt != 4'h0)
                begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
                else if (s_r.s2 == s_r.s3)
                begin
                    s_nxt.rdata = s_r.s3;
                    s_nxt.pins.oe_n = 1'b1;
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = C_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            s_r <= '0;
            s_r.pins.ce_n <= 1'b1;
            s_r.pins.oe_n <= 1'b1;
            // Write strobe high from reset keeps power-up writes from counting.
            s_r.pins.we_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign pins_out = s_r.pins;
    assign rdata_out = s_r.rdata;
    assign done_out = s_r.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_strobe_low;
        (!s_r.pins.we_n && !s_r.pins.ce_n && s_r.pins.oe_n) [*2];
    endsequence

    property p_we_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        $fell(s_r.pins.we_n) |-> s_strobe_low ##1 (s_r.pins.we_n && !s_r.pins.ce_n);
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe shape wrong");

    property p_addr_stable;
        @(posedge clk_in) disable iff (!resetn_in)
        (!s_r.pins.ce_n && $past(!s_r.pins.ce_n)) |-> $stable(s_r.pins.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    property p_no_oe_we;
        @(posedge clk_in) disable iff (!resetn_in)
        !(!s_r.pins.oe_n && !s_r.pins.we_n);
    endproperty
    a_no_oe_we: assert property (p_no_oe_we) else $error("read and write gate both low");

endmodule

// file: src/fcs_host.sv
/*
 * Host side sequencer for a byte-wide command-driven flash: issues reads,
 * resets, identification reads, byte program, chip and sector erase,
 * then, after program and erase, polls status until the device is back in array read.
 * Assumes the flash pins are wired directly and the clock is 10 MHz.
 */

// Notes on behaviour
// - After limit flag, write reset command.
// - Leave identification mode by writing reset.
// - Program is four write cycles.
// - Sector erase is six write cycles.
// - Extra sector writes each within window.
// - Other write during window aborts erase.
// - Host queues sectors without interruption.
module fcs_host (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // User request
    input wire logic USER_REQ_IN,
    input wire fcs_pkg::fcs_cmd_t USER_CMD_IN,
    input wire logic [16:0] USER_ADDR_IN,
    input wire logic [7:0] USER_DATA_IN,
    input wire logic [7:0] USER_SECT_IN,
    // User answer
    output logic USER_READY_OUT,
    output logic USER_DONE_OUT,
    output logic [7:0] USER_RDATA_OUT,
    output logic USER_ERR_OUT,
    output logic USER_WINCLOSED_OUT,
    // Flash pins
    output logic [16:0] FL_ADDR_OUT,
    input wire logic [7:0] FL_DQ_IN,
    output logic [7:0] FL_DQ_OUT,
    output logic [7:0] FL_DQ_OE_OUT,
    output logic FL_CEN_OUT,
    output logic FL_OEN_OUT,
    output logic FL_WEN_OUT
);

    typedef enum logic [2:0] {S_IDLE, S_WR, S_RD, S_POLL, S_EXIT, S_DONE} fcs_st_t;

    typedef struct packed {
        fcs_st_t st;
        fcs_pkg::fcs_cmd_t cmd;
        logic [16:0] addr;
        logic [7:0] data;
        logic [7:0] smask;
        logic [2:0] idx;
        logic pend;
        logic go;
        logic wr;
        fcs_pkg::fcs_bus_t bus;
        logic [7:0] rdata;
        logic [7:0] prev;
        logic have_prev;
        logic lim;
        logic err;
        logic winc;
        logic done;
        logic [9:0] gap;
    } fcs_host_state_t;

    fcs_host_state_t r;
    fcs_host_state_t n;
    fcs_pkg::fcs_pins_t pins;
    logic [7:0] cyc_rdata;
    logic cyc_done;
    logic toggled;

    // ------------------------------------------------------------
    // Command table
    // ------------------------------------------------------------
    function automatic logic [2:0] low_sector(input logic [7:0] m);
        low_sector = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (m[i])
            begin
                low_sector = 3'(i);
            end
        end
    endfunction

    function automatic logic [2:0] last_idx(input fcs_pkg::fcs_cmd_t c);
        case (c)
            fcs_pkg::CMD_IDENT: last_idx = 3'h2;
            fcs_pkg::CMD_PROG: last_idx = 3'h3;
            default: last_idx = 3'h5;
        endcase
    endfunction

    function automatic fcs_pkg::fcs_bus_t step(input fcs_host_state_t s);
        step.addr = fcs_pkg::ADDR_U1;
        step.data = fcs_pkg::DATA_U1;
        case (s.idx)
            3'h0: ;
            3'h1, 3'h4:
            begin
                step.addr = fcs_pkg::ADDR_U2;
                step.data = fcs_pkg::DATA_U2;
            end
            3'h2:
            begin
                case (s.cmd)
                    fcs_pkg::CMD_IDENT: step.data = fcs_pkg::DATA_IDENT;
                    fcs_pkg::CMD_PROG: step.data = fcs_pkg::DATA_PROG;
                    default: step.data = fcs_pkg::DATA_ERASE;
                endcase
            end
            3'h3:
            begin
                if (s.cmd == fcs_pkg::CMD_PROG)
                begin
                    step.addr = s.addr;
                    step.data = s.data;
                end
            end
            default:
            begin
                if (s.cmd == fcs_pkg::CMD_CHIP_ERASE)
                begin
                    step.data = fcs_pkg::DATA_CHIP;
                end
                else
                begin
                    // Sector number rides on the top three address bits.
                    step.addr = {low_sector(s.smask), 14'h0000};
                    step.data = fcs_pkg::DATA_SECT;
                end
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign toggled = r.have_prev && (cyc_rdata[fcs_pkg::BIT_TOGGLE] != r.prev[fcs_pkg::BIT_TOGGLE]);

    always_comb
    begin
        n = r;
        n.go = 1'b0;
        n.done = 1'b0;
        n.gap = (r.gap == 10'h3ff) ? r.gap : r.gap + 10'h001;
        case (r.st)
            S_IDLE:
            begin
                if (USER_REQ_IN)
                begin
                    n.cmd = USER_CMD_IN;
                    n.addr = USER_ADDR_IN;
                    n.data = USER_DATA_IN;
                    n.smask = (USER_SECT_IN == 8'h00) ? 8'h01 : USER_SECT_IN;
                    n.idx = 3'h0;
                    n.pend = 1'b0;
                    n.have_prev = 1'b0;
                    n.lim = 1'b0;
                    n.err = 1'b0;
                    n.winc = 1'b0;
                    case (USER_CMD_IN)
                        fcs_pkg::CMD_READ: n.st = S_RD;
                        fcs_pkg::CMD_RESET: n.st = S_EXIT;
                        default: n.st = S_WR;
                    endcase
                end
            end
            S_WR:
            begin
                if (!r.pend)
                begin
                    // Every write of a sequence is taken from the table in order.
                    n.go = 1'b1;
                    n.wr = 1'b1;
                    n.pend = 1'b1;
                    n.bus = step(r);
                end
                else if (cyc_done)
                begin
                    n.pend = 1'b0;
                    // Gap restarts at every finished write, so the first sector write
                    // is not measured from whatever happened before this request.
                    n.gap = 10'h000;
                    if (r.idx == 3'h5 && r.cmd == fcs_pkg::CMD_SECT_ERASE)
                    begin
                        // Extra sectors follow back to back, well inside the window.
                        n.smask = r.smask & (r.smask - 8'h01);
                        if (n.smask == 8'h00)
                        begin
                            n.st = S_POLL;
                        end
                    end
                    else if (r.idx == last_idx(r.cmd))
                    begin
                        n.st = (r.cmd == fcs_pkg::CMD_IDENT) ? S_RD : S_POLL;
                    end
                    else
                    begin
                        n.idx = r.idx + 3'h1;
                    end
                end
            end
            S_RD:
            begin
                if (!r.pend)
                begin
                    // Identification reads use the low byte as code selector.
                    n.go = 1'b1;
                    n.wr = 1'b0;
                    n.pend = 1'b1;
                    n.bus.addr = r.addr;
                end
                else if (cyc_done)
                begin
                    n.pend = 1'b0;
                    n.rdata = cyc_rdata;
                    n.st = (r.cmd == fcs_pkg::CMD_IDENT) ? S_EXIT : S_DONE;
                end
            end
            S_POLL:
            begin
                // Only reads go out here; a write during the sector window would abort the erase.
                if (!r.pend)
                begin
                    n.go = 1'b1;
                    n.wr = 1'b0;
                    n.pend = 1'b1;
                    n.bus.addr = r.addr;
                end
                else if (cyc_done)
                begin
                    n.pend = 1'b0;
                    n.prev = cyc_rdata;
                    n.have_prev = 1'b1;
                    n.winc = cyc_rdata[fcs_pkg::BIT_WINDOW];
                    if (r.have_prev && !toggled)
                    begin
                        // A stopped toggle bit means array data is back.
                        n.rdata = cyc_rdata;
                        n.err = (r.cmd == fcs_pkg::CMD_PROG) && (cyc_rdata != r.data);
                        n.st = S_DONE;
                    end
                    else if (cyc_rdata[fcs_pkg::BIT_LIMIT])
                    begin
                        // One more read confirms the limit flag before giving up.
                        n.lim = 1'b1;
                        if (r.lim)
                        begin
                            n.err = 1'b1;
                            n.st = S_EXIT;
                        end
                    end
                end
            end
            S_EXIT:
            begin
                if (!r.pend)
                begin
                    n.go = 1'b1;
                    n.wr = 1'b1;
                    n.pend = 1'b1;
                    n.bus.addr = r.addr;
                    n.bus.data = fcs_pkg::DATA_RESET;
                end
                else if (cyc_done)
                begin
                    n.pend = 1'b0;
                    n.st = S_DONE;
                end
            end
            S_DONE:
            begin
                n.done = 1'b1;
                n.st = S_IDLE;
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    fcs_cycle u_cycle (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .go_in(r.go),
        .wr_in(r.wr),
        .bus_in(r.bus),
        .dq_in(FL_DQ_IN),
        .pins_out(pins),
        .rdata_out(cyc_rdata),
        .done_out(cyc_done)
    );

    assign USER_READY_OUT = (r.st == S_IDLE);
    assign USER_DONE_OUT = r.done;
    assign USER_RDATA_OUT = r.rdata;
    assign USER_ERR_OUT = r.err;
    assign USER_WINCLOSED_OUT = r.winc;
    assign FL_ADDR_OUT = pins.addr;
    assign FL_DQ_OUT = pins.dq_out;
    assign FL_DQ_OE_OUT = pins.dq_oe;
    assign FL_CEN_OUT = pins.ce_n;
    assign FL_OEN_OUT = pins.oe_n;
    assign FL_WEN_OUT = pins.we_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_reset_write;
        r.go && r.wr && (r.bus.data == fcs_pkg::DATA_RESET);
    endsequence

    property p_powerup_we;
        @(posedge CLK_IN) $rose(RESETN_IN) |-> FL_WEN_OUT && FL_CEN_OUT;
    endproperty
    a_powerup_we: assert property (p_powerup_we) else $error("strobe low after reset");

    property p_unlock1;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.go && r.st == S_WR && r.idx == 3'h0) |->
            r.bus.addr == 17'h00555 && r.bus.data == 8'haa;
    endproperty
    a_unlock1: assert property (p_unlock1) else $error("first unlock wrong");

    property p_unlock2;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.go && r.st == S_WR && r.idx == 3'h1) |->
            r.bus.addr == 17'h002aa && r.bus.data == 8'h55;
    endproperty
    a_unlock2: assert property (p_unlock2) else $error("second unlock wrong");

    property p_prog_data;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.go && r.st == S_WR && r.cmd == fcs_pkg::CMD_PROG && r.idx == 3'h3) |->
            r.bus.addr == r.addr && r.bus.data == r.data;
    endproperty
    a_prog_data: assert property (p_prog_data) else $error("program cycle wrong");

    property p_ident_exit;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.st == S_RD && r.cmd == fcs_pkg::CMD_IDENT && cyc_done) |-> ##[1:3] s_reset_write;
    endproperty
    a_ident_exit: assert property (p_ident_exit) else $error("no reset after ident");

    property p_limit_exit;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.st == S_POLL && cyc_done && r.lim && toggled && cyc_rdata[5]) |->
            ##[1:3] s_reset_write;
    endproperty
    a_limit_exit: assert property (p_limit_exit) else $error("no reset after limit");

    property p_window_gap;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.go && r.st == S_WR && r.cmd == fcs_pkg::CMD_SECT_ERASE && r.idx == 3'h5) |->
            r.gap < fcs_pkg::WIN_CYC;
    endproperty
    a_window_gap: assert property (p_window_gap) else $error("sector gap too long");

    property p_poll_no_write;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r.st == S_POLL) |-> !(r.go && r.wr);
    endproperty
    a_poll_no_write: assert property (p_poll_no_write) else $error("write during poll");

endmodule

// file: verification/fcs_flash_model.sv
/* Behavioural byte-wide flash device answering the sequencer host.
   Assumes dq_in is the resolved data wire and all strobes are active low. */
module fcs_flash_model #(
    parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value.
    parameter logic [7:0] PART = 8'hc3, // Arbitrary value.
    parameter logic [7:0] PROT = 8'h24
) (
    input wire logic [16:0] a_in,
    input wire logic [7:0] dq_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    output logic [7:0] dq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:131071];
    logic [7:0] v = 8'h0, pd = 8'h0, pend = 8'h0;
    logic [16:0] la = 17'h0;
    logic arm = 1'b0, idm = 1'b0, lim = 1'b0, tog = 1'b0;
    int ph = 0;
    time t_end = 0, t_win = 0;
    wire wr_n = ce_n_in | we_n_in | ~oe_n_in;
    wire rd_n = ce_n_in | oe_n_in;
    wire u1 = la[10:0] == 11'h555;
    wire u2 = la[10:0] == 11'h2aa;
    wire s30 = dq_in == 8'h30;
    // A released bus shows the inverse, so a stale byte never passes for data.
    assign dq_out = rd_n ? ~v : v;
    initial foreach (mem[i]) mem[i] = 8'hff;
    always @(negedge wr_n)
    begin
        la = a_in;
        arm = 1'b1;
    end
    always @(posedge wr_n)
        if (lim)
            lim = dq_in != 8'hf0;
        else if ($time < t_win)
        begin
            pend = s30 ? pend | 8'(1 << la[16:14]) : 8'h0;
            t_win = s30 ? $time + 50000 : 0;
            t_end = s30 ? t_win + 20000 : 0;
        end
        else if (arm && $time >= t_end)
        begin
            if (dq_in == 8'hf0) {idm, ph} = 0;
            else case (ph)
                0: ph = u1 && dq_in == 8'haa ? 1 : 0;
                1: ph = u2 && dq_in == 8'h55 ? 2 : 0;
                2:
                begin
                    idm = u1 && dq_in == 8'h90;
                    ph = !u1 ? 0 : dq_in == 8'ha0 ? 6 : dq_in == 8'h80 ? 3 : 0;
                end
                3: ph = u1 && dq_in == 8'haa ? 4 : 0;
                4: ph = u2 && dq_in == 8'h55 ? 5 : 0;
                5:
                begin
                    ph = 0;
                    pd = 8'hff;
                    pend = s30 ? 8'(1 << la[16:14]) : u1 && dq_in == 8'h10 ? 8'hff : 8'h0;
                    t_win = s30 ? $time + 50000 : 0;
                    t_end = pend == 0 ? 0 : (s30 ? t_win : $time) + 20000;
                end
                6:
                begin
                    ph = 0;
                    pd = dq_in;
                    lim = |(dq_in & ~mem[la]);
                    mem[la] = mem[la] & dq_in;
                    t_end = lim ? 0 : $time + 3000;
                end
                default: ph = 0;
            endcase
        end
    always @(negedge rd_n)
    begin
        #1;
        if ($time >= t_end && pend != 0)
        begin
            foreach (mem[i])
                if (pend[i >> 14]) mem[i] = 8'hff;
            pend = 8'h0;
        end
        if ($time < t_end || lim)
        begin
            v = {~pd[7], tog, lim, 1'b0, $time >= t_win, 3'h0};
            tog = ~tog;
        end
        else if (idm)
            v = a_in[7:0] == 0 ? MAKER : a_in[7:0] == 1 ? PART
                : {7'h0, PROT[a_in[16:14]]};
        else
            v = mem[a_in];
    end
endmodule

// file: verification/fcs_host_tb_top.sv
/* Bench for fcs_host against the flash model; results are queued and checked.
   Assumes one clock and one user request at a time. */
module fcs_host_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, req = 1'b0, rdy, done, err, winc, cen, oen, wen;
    fcs_pkg::fcs_cmd_t cmd = fcs_pkg::CMD_READ;
    logic [16:0] addr = 17'h0, fla, fa, fb, ia;
    logic [7:0] data = 8'h0, sect = 8'h0, d, e, rdat, dqo, oe, mdq;
    logic [9:0] q[$], nt;
    int err_count = 0, comparisons = 0, n;
    wire logic [7:0] dq = (oe & dqo) | (~oe & mdq);
    initial forever #50 clk = ~clk;
    fcs_host DUT (.CLK_IN(clk), .RESETN_IN(rstn), .USER_REQ_IN(req), .USER_CMD_IN(cmd),
        .USER_ADDR_IN(addr), .USER_DATA_IN(data), .USER_SECT_IN(sect), .USER_READY_OUT(rdy),
        .USER_DONE_OUT(done), .USER_RDATA_OUT(rdat), .USER_ERR_OUT(err),
        .USER_WINCLOSED_OUT(winc), .FL_ADDR_OUT(fla), .FL_DQ_IN(dq), .FL_DQ_OUT(dqo),
        .FL_DQ_OE_OUT(oe), .FL_CEN_OUT(cen), .FL_OEN_OUT(oen), .FL_WEN_OUT(wen));
    fcs_flash_model flash (.a_in(fla), .dq_in(dq), .ce_n_in(cen), .oe_n_in(oen),
        .we_n_in(wen), .dq_out(mdq));
    task automatic check(logic [8:0] seen, logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_ready();
        n = 0;
        do
            @(negedge clk) n++;
        while (rdy !== 1'b1 && n < 20000);
        if (rdy !== 1'b1)
        begin
            err_count++;
            summarize();
        end
    endtask
    // Note layout: compare-data flag, expected error, expected data.
    task automatic op(fcs_pkg::fcs_cmd_t c, logic [16:0] a, logic [7:0] dt, logic [7:0] s,
        logic [9:0] note);
        wait_ready();
        q.push_back(note);
        cmd = c;
        addr = a;
        data = dt;
        sect = s;
        req = 1'b1;
        @(negedge clk) req = 1'b0;
    endtask
    always @(negedge clk)
        if (done === 1'b1 && q.size() > 0)
        begin
            nt = q.pop_front();
            check({err, nt[9] ? rdat : nt[7:0]}, nt[8:0]);
            $display("test finished at %0t", $time);
        end
    initial
    begin
        void'($urandom(32'hf3c28413));
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        fa = {3'h2, 14'($urandom)};
        fb = {3'h5, 14'($urandom)};
        d = 8'($urandom) & 8'hfe;
        op(fcs_pkg::CMD_READ, fa, 8'h0, 8'h0, {2'b10, 8'hff});
        op(fcs_pkg::CMD_PROG, fa, d, 8'h0, {2'b10, d});
        op(fcs_pkg::CMD_PROG, fb, d, 8'h0, {2'b10, d});
        op(fcs_pkg::CMD_PROG, fa, 8'hff, 8'h0, {2'b01, 8'h0});
        op(fcs_pkg::CMD_READ, fa, 8'h0, 8'h0, {2'b10, d});
        for (int i = 0; i < 10; i++)
        begin
            e = i < 8 ? {7'h0, flash.PROT[i]} : i == 8 ? flash.MAKER : flash.PART;
            ia = {3'(i), 6'($urandom), i < 8 ? 8'h02 : 8'(i - 8)};
            op(fcs_pkg::CMD_IDENT, ia, 8'h0, 8'h0, {2'b10, e});
        end
        op(fcs_pkg::CMD_READ, fa, 8'h0, 8'h0, {2'b10, d});
        op(fcs_pkg::CMD_RESET, 17'($urandom), 8'h0, 8'h0, {2'b00, 8'h0});
        e = (8'($urandom) | 8'h04) & 8'hdf;
        op(fcs_pkg::CMD_SECT_ERASE, fa, 8'h0, e, {2'b10, 8'hff});
        wait_ready();
        check({8'h0, winc}, 9'h001);
        op(fcs_pkg::CMD_READ, fb, 8'h0, 8'h0, {2'b10, d});
        op(fcs_pkg::CMD_CHIP_ERASE, fb, 8'h0, 8'h0, {2'b10, 8'hff});
        wait_ready();
        @(negedge clk);
        if (q.size() != 0) err_count++;
        summarize();
    end
endmodule
